// *** core/eight_bit_timer_group.sv ***
// Behaviour
// - Bank bit picks X or Y window registers
// - Compare B match sets flag B
// - Compare A match sets flag A
// - Counter wrap FF to 00 sets wrap flag
// - Flags clear by read-1-then-write-0 only
// - X and Y status bits 4:0 read one
// - Match flags set on next counter update
// - Clear select chooses compare A, compare B or external clear
// - Clock select cascade code joins channels zero/one
// - Zero cascade: zero high byte, one low byte
// - Sixteen-bit match for zero, low byte for one
// - Zero clear settings govern whole sixteen-bit counter
// - Channel one clear select ignored when sixteen-bit
// - One cascade: one counts zero compare A
// - Three enabled interrupt lines per channel
// - Fixed priority X, zero, one, Y; A, B, wrap
// - Only compare interrupts start transfer controller
// - Clear beats concurrent counter write
// - Counter write beats concurrent increment
// - Compare write suppresses concurrent compare match
// - High to low source switch counts once
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_group #(
  parameter int NUM_CH = timer_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // Count sources
  input  wire logic [2:0]            internalClk,
  input  wire logic [NUM_CH-1:0]     extClk,
  input  wire logic [NUM_CH-1:0]     extClear,
  // Interrupt and transfer requests
  output var timer_pkg::irq_lines_t  irqLines,
  output var timer_pkg::irq_top_t    irqTop,
  output logic [NUM_CH-1:0]          transferStart
);

  localparam int Z = int'(timer_pkg::CH_ZERO);
  localparam int O = int'(timer_pkg::CH_ONE);

  // Register storage, indexed by channel slot
  logic [7:0]        controlReg  [NUM_CH];
  logic [7:0]        compareAReg [NUM_CH];
  logic [7:0]        compareBReg [NUM_CH];
  logic [NUM_CH-1:0] flagAReg;
  logic [NUM_CH-1:0] flagBReg;
  logic [NUM_CH-1:0] flagWReg;
  logic [NUM_CH-1:0] armAReg;
  logic [NUM_CH-1:0] armBReg;
  logic [NUM_CH-1:0] armWReg;
  logic [7:0]        connectReg;
  logic [7:0]        readDataReg;

  // Bus decode
  timer_pkg::reg_sel_t busSel;
  logic                setupPhase;
  logic                accessPhase;
  logic                busWrite;
  logic                busRead;
  logic [7:0]          wdata;
  logic [7:0]          readMux;

  // Per-channel datapath
  logic [7:0]        count      [NUM_CH];
  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] inc;
  logic [NUM_CH-1:0] update;
  logic [NUM_CH-1:0] wrap;
  logic [NUM_CH-1:0] clear;
  logic [NUM_CH-1:0] eqA;
  logic [NUM_CH-1:0] eqB;
  logic [NUM_CH-1:0] matchA;
  logic [NUM_CH-1:0] matchB;
  logic [NUM_CH-1:0] wrCount;
  logic [NUM_CH-1:0] wrCompA;
  logic [NUM_CH-1:0] wrCompB;
  logic [NUM_CH-1:0] wrCtrl;
  logic [NUM_CH-1:0] wrStat;
  logic [NUM_CH-1:0] rdStat;
  logic              mode16;
  logic              modeCount;

  function automatic timer_pkg::reg_sel_t decode(input logic [31:0] addr, input logic bank);
    timer_pkg::reg_sel_t sel;
    logic [23:0]         idx;
    sel = '{hit: 1'b0, ch: timer_pkg::CH_X, kind: timer_pkg::KIND_NONE};
    idx = addr[25:2];
    if (addr[31:26] == 6'h00 && addr[1:0] == 2'h0) begin
      // Shared window follows the bank bit
      sel.ch = bank ? timer_pkg::CH_Y : timer_pkg::CH_X;
      if (idx == timer_pkg::IDX_WIN_CONTROL) begin
        sel.kind = timer_pkg::KIND_CTRL;
      end else if (idx == timer_pkg::IDX_WIN_STATUS) begin
        sel.kind = timer_pkg::KIND_STAT;
      end else if (idx == timer_pkg::IDX_WIN_COUNTER) begin
        sel.kind = timer_pkg::KIND_CNT;
      end else if (bank && idx == timer_pkg::IDX_Y_COMPARE_A) begin
        sel.kind = timer_pkg::KIND_CMPA;
      end else if (bank && idx == timer_pkg::IDX_Y_COMPARE_B) begin
        sel.kind = timer_pkg::KIND_CMPB;
      end else if (!bank && idx == timer_pkg::IDX_X_COMPARE_A) begin
        sel.kind = timer_pkg::KIND_CMPA;
      end else if (!bank && idx == timer_pkg::IDX_X_COMPARE_B) begin
        sel.kind = timer_pkg::KIND_CMPB;
      end else if (idx == timer_pkg::IDX_CONNECTION) begin
        sel.kind = timer_pkg::KIND_CONN;
      end else if (idx[23:3] == timer_pkg::IDX_ZERO_BASE[23:3]
                   || idx[23:3] == timer_pkg::IDX_ONE_BASE[23:3]) begin
        sel.ch = (idx[23:3] == timer_pkg::IDX_ZERO_BASE[23:3])
                 ? timer_pkg::CH_ZERO : timer_pkg::CH_ONE;
        case (idx[2:0])
          timer_pkg::SUB_CONTROL:   sel.kind = timer_pkg::KIND_CTRL;
          timer_pkg::SUB_STATUS:    sel.kind = timer_pkg::KIND_STAT;
          timer_pkg::SUB_COMPARE_A: sel.kind = timer_pkg::KIND_CMPA;
          timer_pkg::SUB_COMPARE_B: sel.kind = timer_pkg::KIND_CMPB;
          timer_pkg::SUB_COUNTER:   sel.kind = timer_pkg::KIND_CNT;
          default:                  sel.kind = timer_pkg::KIND_NONE;
        endcase
      end
    end
    sel.hit = (sel.kind != timer_pkg::KIND_NONE);
    return sel;
  endfunction

  assign busSel      = decode(paddr, connectReg[timer_pkg::BANK_BIT]);
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign busWrite    = accessPhase & pwrite & busSel.hit;
  assign busRead     = accessPhase & ~pwrite & busSel.hit;
  assign wdata       = pwdata[7:0];

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = accessPhase;
  assign pslverr = accessPhase & ~busSel.hit;
  assign prdata  = {24'h000000, readDataReg};

  always_comb begin
    readMux = 8'h00;
    case (busSel.kind)
      timer_pkg::KIND_CTRL: readMux = controlReg[busSel.ch];
      timer_pkg::KIND_STAT: readMux = {flagBReg[busSel.ch], flagAReg[busSel.ch],
                                       flagWReg[busSel.ch], timer_pkg::ST_FIXED_ONES};
      timer_pkg::KIND_CMPA: readMux = compareAReg[busSel.ch];
      timer_pkg::KIND_CMPB: readMux = compareBReg[busSel.ch];
      timer_pkg::KIND_CNT:  readMux = count[busSel.ch];
      timer_pkg::KIND_CONN: readMux = connectReg;
      default:              readMux = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and held through access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readDataReg <= 8'h00;
    end else if (setupPhase) begin
      readDataReg <= readMux;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      connectReg <= timer_pkg::CONNECT_RST;
    end else if (busWrite && busSel.kind == timer_pkg::KIND_CONN) begin
      connectReg <= wdata;
    end
  end

  // Cascade modes
  assign mode16    = controlReg[Z][timer_pkg::CTL_CKS_MSB:0] == timer_pkg::CKS_CASCADE;
  assign modeCount = controlReg[O][timer_pkg::CTL_CKS_MSB:0] == timer_pkg::CKS_CASCADE;

  always_comb begin
    inc = tick;
    if (mode16 && modeCount) begin
      inc[Z] = 1'b0;
      inc[O] = 1'b0;
    end else if (mode16) begin
      inc[Z] = wrap[O];
    end else if (modeCount) begin
      inc[O] = matchA[Z];
    end
  end

  // Compare against the counter; channel zero widens when cascaded
  always_comb begin
    eqA    = '0;
    eqB    = '0;
    update = inc;
    for (int i = 0; i < NUM_CH; i++) begin
      eqA[i] = (count[i] == compareAReg[i]);
      eqB[i] = (count[i] == compareBReg[i]);
    end
    if (mode16) begin
      eqA[Z]    = ({count[Z], count[O]} == {compareAReg[Z], compareAReg[O]});
      eqB[Z]    = ({count[Z], count[O]} == {compareBReg[Z], compareBReg[O]});
      update[Z] = inc[O];
    end
  end

  // Match fires while equal at the moment the counter updates
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      matchA[i] = update[i] & eqA[i] & ~wrCompA[i];
      matchB[i] = update[i] & eqB[i] & ~wrCompB[i];
    end
    if (mode16) begin
      matchA[Z] = update[Z] & eqA[Z] & ~wrCompA[Z] & ~wrCompA[O];
      matchB[Z] = update[Z] & eqB[Z] & ~wrCompB[Z] & ~wrCompB[O];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      case (controlReg[i][timer_pkg::CTL_CLR_HI:timer_pkg::CTL_CLR_LO])
        timer_pkg::CLR_CMP_A: clear[i] = matchA[i];
        timer_pkg::CLR_CMP_B: clear[i] = matchB[i];
        timer_pkg::CLR_EXT:   clear[i] = extClear[i];
        default:              clear[i] = 1'b0;
      endcase
    end
    if (mode16) begin
      clear[O] = clear[Z];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      assign wrCount[g] = busWrite && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_CNT;
      assign wrCompA[g] = busWrite && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_CMPA;
      assign wrCompB[g] = busWrite && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_CMPB;
      assign wrCtrl[g]  = busWrite && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_CTRL;
      assign wrStat[g]  = busWrite && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_STAT;
      assign rdStat[g]  = busRead && busSel.ch == 2'(g) && busSel.kind == timer_pkg::KIND_STAT;

      clock_edge_select u_src (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .clockSel    (controlReg[g][timer_pkg::CTL_CKS_MSB:0]),
        .internalClk (internalClk),
        .extClk      (extClk[g]),
        .tick        (tick[g])
      );

      counter_core u_cnt (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clear     (clear[g]),
        .write     (wrCount[g]),
        .writeData (wdata),
        .inc       (inc[g]),
        .count     (count[g]),
        .wrap      (wrap[g])
      );

      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          controlReg[g]  <= timer_pkg::CONTROL_RST;
          compareAReg[g] <= timer_pkg::COMPARE_RST;
          compareBReg[g] <= timer_pkg::COMPARE_RST;
        end else begin
          if (wrCtrl[g]) begin
            controlReg[g] <= wdata;
          end
          if (wrCompA[g]) begin
            compareAReg[g] <= wdata;
          end
          if (wrCompB[g]) begin
            compareBReg[g] <= wdata;
          end
        end
      end

      // A read returning one arms the clear; any status write disarms
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          armAReg[g] <= 1'b0;
          armBReg[g] <= 1'b0;
          armWReg[g] <= 1'b0;
        end else if (rdStat[g]) begin
          armAReg[g] <= armAReg[g] | readDataReg[timer_pkg::ST_FLAG_A];
          armBReg[g] <= armBReg[g] | readDataReg[timer_pkg::ST_FLAG_B];
          armWReg[g] <= armWReg[g] | readDataReg[timer_pkg::ST_FLAG_W];
        end else if (wrStat[g]) begin
          armAReg[g] <= 1'b0;
          armBReg[g] <= 1'b0;
          armWReg[g] <= 1'b0;
        end
      end

      // Hardware set wins over a same-cycle software clear
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          flagAReg[g] <= 1'b0;
          flagBReg[g] <= 1'b0;
          flagWReg[g] <= 1'b0;
        end else begin
          flagAReg[g] <= matchA[g] | (flagAReg[g] & ~(wrStat[g] & armAReg[g]
                         & ~wdata[timer_pkg::ST_FLAG_A]));
          flagBReg[g] <= matchB[g] | (flagBReg[g] & ~(wrStat[g] & armBReg[g]
                         & ~wdata[timer_pkg::ST_FLAG_B]));
          flagWReg[g] <= wrap[g] | (flagWReg[g] & ~(wrStat[g] & armWReg[g]
                         & ~wdata[timer_pkg::ST_FLAG_W]));
        end
      end

      assign irqLines.cmpA[g] = flagAReg[g] & controlReg[g][timer_pkg::CTL_IRQ_A];
      assign irqLines.cmpB[g] = flagBReg[g] & controlReg[g][timer_pkg::CTL_IRQ_B];
      assign irqLines.wrap[g] = flagWReg[g] & controlReg[g][timer_pkg::CTL_IRQ_W];
      assign transferStart[g] = irqLines.cmpA[g] | irqLines.cmpB[g];
    end
  endgenerate

  // Highest pending request, scanned from lowest rank upward
  always_comb begin
    logic [1:0] order [4];
    order[0] = timer_pkg::CH_Y;
    order[1] = timer_pkg::CH_ONE;
    order[2] = timer_pkg::CH_ZERO;
    order[3] = timer_pkg::CH_X;
    irqTop = '{valid: 1'b0, ch: 2'h0, src: 2'h0};
    for (int k = 0; k < 4; k++) begin
      if (irqLines.wrap[order[k]]) begin
        irqTop = '{valid: 1'b1, ch: order[k], src: 2'h2};
      end
      if (irqLines.cmpB[order[k]]) begin
        irqTop = '{valid: 1'b1, ch: order[k], src: 2'h1};
      end
      if (irqLines.cmpA[order[k]]) begin
        irqTop = '{valid: 1'b1, ch: order[k], src: 2'h0};
      end
    end
  end

endmodule
`default_nettype wire

// *** core/timer_pkg.sv ***
`default_nettype none
package timer_pkg;

  // Channel slots
  localparam int NUM_CH = 4;
  localparam logic [1:0] CH_ZERO = 2'h0;
  localparam logic [1:0] CH_ONE  = 2'h1;
  localparam logic [1:0] CH_X    = 2'h2;
  localparam logic [1:0] CH_Y    = 2'h3;

  // Register indices; byte address is four times the index
  localparam logic [23:0] IDX_WIN_CONTROL = 24'hfffff0;
  localparam logic [23:0] IDX_WIN_STATUS  = 24'hfffff1;
  localparam logic [23:0] IDX_Y_COMPARE_A = 24'hfffff2;
  localparam logic [23:0] IDX_Y_COMPARE_B = 24'hfffff3;
  localparam logic [23:0] IDX_WIN_COUNTER = 24'hfffff4;
  localparam logic [23:0] IDX_X_COMPARE_A = 24'hfffff6;
  localparam logic [23:0] IDX_X_COMPARE_B = 24'hfffff7;
  localparam logic [23:0] IDX_ZERO_BASE   = 24'hffffe0;
  localparam logic [23:0] IDX_ONE_BASE    = 24'hffffe8;
  localparam logic [23:0] IDX_CONNECTION  = 24'hffffee;
  localparam logic [2:0]  SUB_CONTROL     = 3'h0;
  localparam logic [2:0]  SUB_STATUS      = 3'h1;
  localparam logic [2:0]  SUB_COMPARE_A   = 3'h2;
  localparam logic [2:0]  SUB_COMPARE_B   = 3'h3;
  localparam logic [2:0]  SUB_COUNTER     = 3'h4;

  // Control register fields
  localparam int CTL_IRQ_B   = 7;
  localparam int CTL_IRQ_A   = 6;
  localparam int CTL_IRQ_W   = 5;
  localparam int CTL_CLR_HI  = 4;
  localparam int CTL_CLR_LO  = 3;
  localparam int CTL_CKS_MSB = 2;
  localparam logic [1:0] CLR_CMP_A = 2'h1;
  localparam logic [1:0] CLR_CMP_B = 2'h2;
  localparam logic [1:0] CLR_EXT   = 2'h3;
  localparam logic [2:0] CKS_INT0     = 3'h1;
  localparam logic [2:0] CKS_INT2     = 3'h3;
  localparam logic [2:0] CKS_CASCADE  = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // Status register fields
  localparam int ST_FLAG_B = 7;
  localparam int ST_FLAG_A = 6;
  localparam int ST_FLAG_W = 5;
  localparam logic [4:0] ST_FIXED_ONES = 5'h1f;
  localparam int BANK_BIT = 7;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'hff;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] CONNECT_RST = 8'h00;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_CTRL = 3'b001,
    KIND_STAT = 3'b010,
    KIND_CMPA = 3'b011,
    KIND_CMPB = 3'b100,
    KIND_CNT  = 3'b101,
    KIND_CONN = 3'b110
  } reg_kind_t;

  typedef struct packed {
    logic      hit;
    logic [1:0] ch;
    reg_kind_t kind;
  } reg_sel_t;

  typedef struct packed {
    logic [3:0] cmpA;
    logic [3:0] cmpB;
    logic [3:0] wrap;
  } irq_lines_t;

  // Source code: 0 compare A, 1 compare B, 2 wrap
  typedef struct packed {
    logic       valid;
    logic [1:0] ch;
    logic [1:0] src;
  } irq_top_t;

endpackage
`default_nettype wire

// *** core/clock_edge_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_edge_select (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Source selection
  input  wire logic [2:0] clockSel,
  input  wire logic [2:0] internalClk,
  input  wire logic       extClk,
  // Count strobe
  output logic            tick
);

  logic intLevel;
  logic intLevelReg;
  logic extPrevReg;
  logic extTick;

  // Non-internal selections look like a low level
  always_comb begin
    intLevel = 1'b0;
    if (clockSel >= timer_pkg::CKS_INT0 && clockSel <= timer_pkg::CKS_INT2) begin
      intLevel = internalClk[clockSel[1:0] - 2'h1];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      intLevelReg <= 1'b0;
      extPrevReg  <= 1'b0;
    end else begin
      intLevelReg <= intLevel;
      extPrevReg  <= extClk;
    end
  end

  always_comb begin
    case (clockSel)
      timer_pkg::CKS_EXT_RISE: extTick = extClk & ~extPrevReg;
      timer_pkg::CKS_EXT_FALL: extTick = ~extClk & extPrevReg;
      timer_pkg::CKS_EXT_BOTH: extTick = extClk ^ extPrevReg;
      default:                 extTick = 1'b0;
    endcase
  end

  // A switch from a high source to a low one counts as a falling edge
  assign tick = (intLevelReg & ~intLevel) | extTick;

endmodule
`default_nettype wire

// *** core/counter_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module counter_core (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Counter control
  input  wire logic       clear,
  input  wire logic       write,
  input  wire logic [7:0] writeData,
  input  wire logic       inc,
  // Counter state
  output logic [7:0]      count,
  output logic            wrap
);

  logic [7:0] countReg;
  logic [7:0] countNext;

  always_comb begin
    countNext = countReg;
    if (clear) begin
      countNext = timer_pkg::COUNTER_RST;
    end else if (write) begin
      countNext = writeData;
    end else if (inc) begin
      countNext = countReg + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      countReg <= timer_pkg::COUNTER_RST;
    end else begin
      countReg <= countNext;
    end
  end

  assign count = countReg;
  assign wrap  = inc & ~clear & ~write & (countReg == 8'hff);

endmodule
`default_nettype wire

// *** testbench/eight_bit_timer_group_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_group_props #(
  parameter int NUM_CH = timer_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  sys_rst,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  // Requests
  input wire timer_pkg::irq_lines_t irqLines,
  input wire timer_pkg::irq_top_t   irqTop,
  input wire logic [NUM_CH-1:0]     transferStart
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable;
  endsequence

  property p_ready;
    s_setup ##1 s_acc |-> pready;
  endproperty
  property p_rd_high;
    s_setup ##1 (s_acc and !pwrite) |-> prdata[31:8] == 24'h000000;
  endproperty
  property p_rd_refused;
    s_acc and !pwrite and pslverr |-> prdata == 32'h00000000;
  endproperty
  property p_win_hole;
    s_acc and (paddr == 32'h03ffffd4) |-> pslverr;
  endproperty
  property p_xfer;
    transferStart == (irqLines.cmpA | irqLines.cmpB);
  endproperty
  property p_valid;
    irqTop.valid == (|irqLines);
  endproperty
  property p_top_xa;
    irqLines.cmpA[2] |-> irqTop.ch == timer_pkg::CH_X && irqTop.src == 2'h0;
  endproperty
  property p_top_xb;
    irqLines.cmpB[2] && !irqLines.cmpA[2] |-> irqTop.ch == timer_pkg::CH_X && irqTop.src == 2'h1;
  endproperty
  property p_y_last;
    irqTop.valid && irqTop.ch == timer_pkg::CH_Y
      |-> (irqLines.cmpA[2:0] | irqLines.cmpB[2:0] | irqLines.wrap[2:0]) == 3'h0;
  endproperty
  property p_fall;
    (12'($past(irqLines)) & ~12'(irqLines)) != 12'h000 |-> $past(psel && penable && pwrite);
  endproperty

  a_ready: assert property (p_ready) else $error("no zero wait answer");
  a_rd_high: assert property (p_rd_high) else $error("read data upper bits set");
  a_rd_refused: assert property (p_rd_refused) else $error("refused read not zero");
  a_win_hole: assert property (p_win_hole) else $error("window hole accepted");
  a_xfer: assert property (p_xfer) else $error("transfer start mismatch");
  a_valid: assert property (p_valid) else $error("top valid mismatch");
  a_top_xa: assert property (p_top_xa) else $error("X compare A not on top");
  a_top_xb: assert property (p_top_xb) else $error("X compare B not on top");
  a_y_last: assert property (p_y_last) else $error("Y above higher request");
  a_fall: assert property (p_fall) else $error("request fell without write");
endmodule
bind eight_bit_timer_group eight_bit_timer_group_props #(.NUM_CH(NUM_CH)) u_props (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .irqLines(irqLines), .irqTop(irqTop), .transferStart(transferStart)
);
`default_nettype wire

// *** testbench/eight_bit_timer_group_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_group_tb_top;
  typedef struct packed {
    logic        w;
    logic [23:0] idx;
    logic [7:0]  d;
    logic        err;
  } row_t;

  logic                  clock;
  logic                  sys_rst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [31:0]           paddr;
  logic [31:0]           pwdata;
  logic                  pready;
  logic                  pslverr;
  logic [31:0]           prdata;
  logic [2:0]            internalClk;
  logic [3:0]            extClk;
  logic [3:0]            extClear;
  timer_pkg::irq_lines_t irqLines;
  timer_pkg::irq_top_t   irqTop;
  logic [3:0]            transferStart;
  logic [11:0]           irqFlat;
  int                    n_fail;
  int                    total_checks;
  row_t                  rows [16];

  assign irqFlat = irqLines;

  eight_bit_timer_group dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .internalClk(internalClk), .extClk(extClk), .extClear(extClear),
    .irqLines(irqLines), .irqTop(irqTop), .transferStart(transferStart)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Prescaled sources: bit 0 falls every second cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      internalClk <= 3'h0;
    end else begin
      internalClk <= internalClk + 3'h1;
    end
  end

  task automatic end_of_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [23:0] i, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h00, i, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (k == 100) begin
      n_fail++;
      $display("BAD %0t bus timeout", $time);
      end_of_test();
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [23:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, i, d, q, e);
  endtask

  task automatic rd(input logic [23:0] i, input logic [7:0] x);
    logic [7:0] q;
    logic       e;
    apb(1'b0, i, 8'h00, q, e);
    check(12'(q), 12'(x));
  endtask

  task automatic waitIrq(input int b);
    for (int k = 0; k < 3000; k++) begin
      @(posedge clock);
      if (irqFlat[b] === 1'b1) return;
    end
    n_fail++;
    $display("BAD %0t request wait timeout", $time);
    end_of_test();
  endtask

  function automatic logic [23:0] at(input logic [23:0] b, input logic [2:0] s);
    return b + 24'(s);
  endfunction

  initial begin
    logic [7:0] q;
    logic       e;
    rows = '{
      '{1'b0, timer_pkg::IDX_CONNECTION, 8'h00, 1'b0},
      '{1'b0, timer_pkg::IDX_WIN_CONTROL, 8'h00, 1'b0},
      '{1'b0, timer_pkg::IDX_WIN_STATUS, 8'h1f, 1'b0},
      '{1'b1, timer_pkg::IDX_WIN_STATUS, 8'hff, 1'b0},
      '{1'b0, timer_pkg::IDX_WIN_STATUS, 8'h1f, 1'b0},
      '{1'b0, timer_pkg::IDX_X_COMPARE_A, 8'hff, 1'b0},
      '{1'b1, timer_pkg::IDX_X_COMPARE_A, 8'h5a, 1'b0},
      '{1'b0, timer_pkg::IDX_X_COMPARE_A, 8'h5a, 1'b0},
      '{1'b0, timer_pkg::IDX_Y_COMPARE_A, 8'h00, 1'b1},
      '{1'b1, timer_pkg::IDX_CONNECTION, 8'h80, 1'b0},
      '{1'b1, timer_pkg::IDX_Y_COMPARE_A, 8'h33, 1'b0},
      '{1'b0, timer_pkg::IDX_Y_COMPARE_A, 8'h33, 1'b0},
      '{1'b0, timer_pkg::IDX_X_COMPARE_A, 8'h00, 1'b1},
      '{1'b0, timer_pkg::IDX_WIN_STATUS, 8'h1f, 1'b0},
      '{1'b1, timer_pkg::IDX_CONNECTION, 8'h00, 1'b0},
      '{1'b0, 24'hfffff5, 8'h00, 1'b1}
    };
    n_fail = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    extClk = 4'h0;
    extClear = 4'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].d, q, e);
      check(12'(e), 12'(rows[i].err));
      if (!rows[i].w) check(12'(q), 12'(rows[i].d));
    end
    // X compares with clear on A
    wr(timer_pkg::IDX_X_COMPARE_B, 8'h02);
    wr(timer_pkg::IDX_X_COMPARE_A, 8'h03);
    wr(timer_pkg::IDX_WIN_CONTROL, 8'hc9);
    waitIrq(10);
    check(12'(irqTop), 12'({1'b1, timer_pkg::CH_X, 2'h0}));
    check(12'(transferStart), 12'h004);
    wr(timer_pkg::IDX_WIN_CONTROL, 8'hc8);
    wr(timer_pkg::IDX_WIN_STATUS, 8'h00);
    rd(timer_pkg::IDX_WIN_STATUS, 8'hdf);
    wr(timer_pkg::IDX_WIN_STATUS, 8'h00);
    rd(timer_pkg::IDX_WIN_STATUS, 8'h1f);
    check(irqFlat, 12'h000);
    // Y wrap through FF
    wr(timer_pkg::IDX_CONNECTION, 8'h80);
    wr(timer_pkg::IDX_WIN_CONTROL, 8'h21);
    wr(timer_pkg::IDX_WIN_COUNTER, 8'hfe);
    waitIrq(3);
    check(12'(transferStart), 12'h000);
    check(12'(irqTop), 12'({1'b1, timer_pkg::CH_Y, 2'h2}));
    wr(timer_pkg::IDX_WIN_CONTROL, 8'h20);
    rd(timer_pkg::IDX_WIN_STATUS, 8'hbf);
    wr(timer_pkg::IDX_WIN_STATUS, 8'h00);
    rd(timer_pkg::IDX_WIN_STATUS, 8'h1f);
    wr(timer_pkg::IDX_CONNECTION, 8'h00);
    // Sixteen-bit cascade: low byte wrap carries
    wr(at(timer_pkg::IDX_ZERO_BASE, timer_pkg::SUB_CONTROL), 8'h04);
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_COUNTER), 8'hfe);
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_CONTROL), 8'h21);
    waitIrq(1);
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_CONTROL), 8'h20);
    rd(at(timer_pkg::IDX_ZERO_BASE, timer_pkg::SUB_COUNTER), 8'h01);
    // Both cascade codes: counters stand
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_CONTROL), 8'h24);
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_COUNTER), 8'h10);
    repeat (20) @(posedge clock);
    rd(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_COUNTER), 8'h10);
    // Sixteen-bit clear follows channel zero only
    wr(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_CONTROL), 8'h18);
    wr(at(timer_pkg::IDX_ZERO_BASE, timer_pkg::SUB_CONTROL), 8'h1c);
    @(posedge clock) extClear <= 4'h2;
    @(posedge clock) extClear <= 4'h0;
    rd(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_COUNTER), 8'h10);
    @(posedge clock) extClear <= 4'h1;
    @(posedge clock) extClear <= 4'h0;
    rd(at(timer_pkg::IDX_ONE_BASE, timer_pkg::SUB_COUNTER), 8'h00);
    rd(at(timer_pkg::IDX_ZERO_BASE, timer_pkg::SUB_COUNTER), 8'h00);
    // Reset in mid-run
    wr(timer_pkg::IDX_CONNECTION, 8'h80);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(timer_pkg::IDX_CONNECTION, 8'h00);
    rd(timer_pkg::IDX_X_COMPARE_A, 8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
